//--- verilog/fbr_top.sv
`timescale 1ns/1ns
// What this block does
// (R01) read words leave as a continuous stream of 32-bit data words
// (R02) incrementing bursts accept any length from 1 up to 128 words
// (R03) wrapping bursts use a fixed length of 2 or 4 words per variant
// (R04) master raises read with legal burst count and legal word address
// (R05) waitrequest stays high whenever a new command cannot be taken
// (R06) each returned word is marked by a valid-data cycle with its data
// (R07) in incrementing bursts, reaching the last location continues at the first location
// (R08) busy field reads 2'b11 while a read is in progress
// (R09) good read sets success; illegal or protected clears it, raises empty
// (R10) wrapping bursts are offered only with the parallel interface
// (R11) unaligned wrapping start addresses are accepted and wrapped
// (R12) 2-word wrap returns to the preceding 2-word boundary
// (R13) 4-word wrap returns to the preceding 4-word boundary
// (R14) locations not initialised read as all ones
// (R15) initialisation data past the flash size is discarded
// (R16) serial interface uses only incrementing bursts
// (R17) single reads use burst count 1 parallel, 32 serial; serial mode also reads one word for count 1, and 32 returns 32 words
// (R18) incrementing bursts return ascending words from the start address

`include "fbr_map.svh"

// simple flop fifo with valid/ready on both sides
module fbr_fifo import fbr_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // handshakes
  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : fbr_fifo

module fbr_top import fbr_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int MEM_WORDS = 256,
  parameter int NSECT = 2,
  parameter int BURST_W = 8,
  parameter int BURST_LIMIT = 128,
  parameter int WRAP_LEN = 4,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // data read port
  input wire logic DATA_READ_I,
  input wire logic [ADDR_W-1:0] DATA_ADDR_I,
  input wire logic [BURST_W-1:0] DATA_BURST_I,
  output logic DATA_WAITREQUEST_O,
  output logic DATA_VALID_O,
  input wire logic DATA_READY_I,
  output logic [31:0] DATA_RDATA_O,
  // busy code of the neighbouring program/erase logic
  input wire logic [1:0] BUSY_EXT_I,
  // control bus write channels
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  output logic [1:0] AXI_BRESP_O,
  // control bus read channels
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  input wire logic [7:0] AXI_ARADDR_I,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O
);
  localparam int IDX_W = $clog2(MEM_WORDS);
  localparam int SEC_W = $clog2(NSECT);
  localparam logic [ADDR_W-1:0] WMASK = ADDR_W'(WRAP_LEN-1);

  fbr_state_e state_q;
  fbr_cfg_s cfg_q;
  fbr_status_s status;
  logic [NSECT-1:0] prot_q;
  logic [31:0] mem_q [MEM_WORDS];
  logic [ADDR_W-1:0] init_addr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [BURST_W:0] left_q;
  logic wrap_q;
  logic bad_q;
  logic ok_q;
  logic empty_q;
  logic wrap_eff;
  logic burst_ok;
  logic take;
  logic legal;
  logic [31:0] word;
  logic fifo_ready;
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic push;
  logic pop;
  logic last;
  logic out_valid_q;
  logic [31:0] out_data_q;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic do_wr;
  logic init_we;
  logic empty_clr;

  // command acceptance
  assign DATA_WAITREQUEST_O = (state_q != ST_IDLE) || (BUSY_EXT_I != `FBR_BUSY_IDLE); // R05
  assign wrap_eff = cfg_q.wrap && !cfg_q.serial; // R10 R16
  assign burst_ok = wrap_eff ? (DATA_BURST_I == BURST_W'(WRAP_LEN)) // R03
                             : (DATA_BURST_I != '0 && DATA_BURST_I <= BURST_W'(BURST_LIMIT)); // R02
  assign take = DATA_READ_I && !DATA_WAITREQUEST_O;

  // current word lookup, blank for illegal or protected locations
  assign legal = (addr_q < ADDR_W'(MEM_WORDS)) && !prot_q[addr_q[IDX_W-1 -: SEC_W]]; // R09
  assign word = legal ? mem_q[addr_q[IDX_W-1:0]] : `FBR_BLANK_WORD; // R14
  assign push = (state_q == ST_READ) && fifo_ready;
  assign last = push && (left_q == (BURST_W+1)'(1));

  // next address: wrap inside the burst block, or ascend and roll over at the end
  always_comb begin
    if (wrap_q) begin
      addr_d = (addr_q & ~WMASK) | ((addr_q + 1'b1) & WMASK); // R11 R12 R13
    end else if (addr_q == ADDR_W'(MEM_WORDS-1)) begin
      addr_d = '0; // R07
    end else begin
      addr_d = addr_q + 1'b1; // R18
    end
  end

  // read engine
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      left_q <= '0;
      wrap_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && burst_ok) begin
            state_q <= ST_READ;
            addr_q <= DATA_ADDR_I;
            left_q <= {1'b0, DATA_BURST_I};
            wrap_q <= wrap_eff;
            bad_q <= 1'b0;
          end
        end
        ST_READ: begin
          if (push) begin
            addr_q <= addr_d;
            left_q <= left_q - 1'b1;
            bad_q <= bad_q || !legal;
            if (last) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // success and empty flags; hardware set wins over software clear
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ok_q <= 1'b0;
      empty_q <= 1'b0;
    end else begin
      if (last) begin
        ok_q <= !bad_q && legal; // R09
      end else if (take && !burst_ok) begin
        ok_q <= 1'b0;
      end
      if ((last && !(bad_q == 1'b0 && legal)) || (take && !burst_ok)) begin
        empty_q <= 1'b1; // R09
      end else if (empty_clr) begin
        empty_q <= 1'b0;
      end
    end
  end

  // status word
  assign status = {empty_q, ok_q, ((state_q == ST_READ) ? `FBR_BUSY_READ : BUSY_EXT_I)}; // R08

  // word buffer between flash and port
  fbr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) fbr_fifo_inst (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .in_valid_i(state_q == ST_READ),
    .in_ready_o(fifo_ready),
    .in_data_i(word),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // registered output stage
  assign pop = fifo_valid && (!out_valid_q || DATA_READY_I);
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1; // R06
      out_data_q <= fifo_data; // R01
    end else if (DATA_READY_I) begin
      out_valid_q <= 1'b0;
    end
  end
  assign DATA_VALID_O = out_valid_q;
  assign DATA_RDATA_O = out_data_q;

  // write address/data capture, in either order
  assign AXI_AWREADY_O = !aw_q;
  assign AXI_WREADY_O = !w_q;
  assign do_wr = aw_q && w_q && !AXI_BVALID_O;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= `FBR_RESP_OKAY;
    end else begin
      if (AXI_AWVALID_I && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && !w_q) begin
        w_q <= 1'b1;
        wdata_q <= AXI_WDATA_I;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O <= (awaddr_q <= `FBR_OFS_INIT_DATA && awaddr_q[1:0] == 2'h0) ? `FBR_RESP_OKAY
                                                                                 : `FBR_RESP_SLVERR;
      end else if (AXI_BREADY_I) begin
        AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // register writes
  assign empty_clr = do_wr && awaddr_q == `FBR_OFS_STATUS && wdata_q[`FBR_ST_EMPTY_BIT];
  assign init_we = do_wr && awaddr_q == `FBR_OFS_INIT_DATA && init_addr_q < ADDR_W'(MEM_WORDS); // R15
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      cfg_q <= `FBR_RST_CONFIG;
      prot_q <= {NSECT{`FBR_RST_PROTECT}};
      init_addr_q <= '0;
    end else if (do_wr) begin
      case (awaddr_q)
        `FBR_OFS_CONFIG: cfg_q <= {wdata_q[`FBR_CFG_SERIAL_BIT], wdata_q[`FBR_CFG_WRAP_BIT]};
        `FBR_OFS_PROTECT: prot_q <= wdata_q[NSECT-1:0];
        `FBR_OFS_INIT_ADDR: init_addr_q <= wdata_q[ADDR_W-1:0];
        `FBR_OFS_INIT_DATA: init_addr_q <= init_addr_q + 1'b1;
        default: ;
      endcase
    end
  end

  // flash array, blank after reset, loaded through the init window
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_q[i] <= `FBR_BLANK_WORD; // R14
      end
    end else if (init_we) begin
      mem_q[init_addr_q[IDX_W-1:0]] <= wdata_q; // R15
    end
  end

  // register reads
  assign AXI_ARREADY_O = !AXI_RVALID_O;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= '0;
      AXI_RRESP_O <= `FBR_RESP_OKAY;
    end else if (AXI_ARVALID_I && !AXI_RVALID_O) begin
      AXI_RVALID_O <= 1'b1;
      AXI_RRESP_O <= `FBR_RESP_OKAY;
      case (AXI_ARADDR_I)
        `FBR_OFS_STATUS: AXI_RDATA_O <= {28'h0000000, status};
        `FBR_OFS_CONFIG: AXI_RDATA_O <= {30'h0, cfg_q};
        `FBR_OFS_PROTECT: AXI_RDATA_O <= 32'(prot_q);
        `FBR_OFS_INIT_ADDR: AXI_RDATA_O <= 32'(init_addr_q);
        `FBR_OFS_INIT_DATA: AXI_RDATA_O <= '0;
        default: begin
          AXI_RDATA_O <= '0;
          AXI_RRESP_O <= `FBR_RESP_SLVERR;
        end
      endcase
    end else if (AXI_RREADY_I) begin
      AXI_RVALID_O <= 1'b0;
    end
  end

  // checks
  a_wait_during_read: assert property (@(posedge CLK_I) disable iff (RESET_I) // R05
    state_q == ST_READ |-> DATA_WAITREQUEST_O) else $error("command accepted mid-burst");
  a_busy_read_code: assert property (@(posedge CLK_I) disable iff (RESET_I) // R08
    take && burst_ok |=> status.busy == 2'h3) else $error("busy code not read");
  a_valid_holds: assert property (@(posedge CLK_I) disable iff (RESET_I) // R06
    DATA_VALID_O && !DATA_READY_I |=> DATA_VALID_O && $stable(DATA_RDATA_O)) else $error("word lost");
  a_incr_ascend: assert property (@(posedge CLK_I) disable iff (RESET_I) // R18
    push && !wrap_q && !last && addr_q != ADDR_W'(MEM_WORDS-1) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("address not ascending");
  a_end_rollover: assert property (@(posedge CLK_I) disable iff (RESET_I) // R07
    push && !last && addr_q == ADDR_W'(MEM_WORDS-1) && !wrap_q |=> addr_q == '0) else $error("no rollover");
  a_wrap_block: assert property (@(posedge CLK_I) disable iff (RESET_I) // R12 R13
    push && wrap_q && !last |=> (addr_q & ~WMASK) == ($past(addr_q) & ~WMASK))
    else $error("wrap left its block");
  a_wrap_parallel: assert property (@(posedge CLK_I) disable iff (RESET_I) // R10
    take && burst_ok && cfg_q.serial |=> !wrap_q) else $error("wrap on serial");
  a_burst_limit: assert property (@(posedge CLK_I) disable iff (RESET_I) // R02
    take && burst_ok |=> left_q <= (BURST_W+1)'(BURST_LIMIT) && left_q != '0) else $error("burst too long");
  a_blank_word: assert property (@(posedge CLK_I) disable iff (RESET_I) // R09
    push && !legal |-> word == `FBR_BLANK_WORD) else $error("illegal read not blank");
  a_fail_flags: assert property (@(posedge CLK_I) disable iff (RESET_I) // R09
    last && !legal |=> !ok_q && empty_q) else $error("fail flags wrong");
  a_init_bound: assert property (@(posedge CLK_I) disable iff (RESET_I) // R15
    init_we |-> init_addr_q < ADDR_W'(MEM_WORDS)) else $error("init past array");

endmodule : fbr_top

//--- verilog/fbr_map.svh
`ifndef FBR_MAP_SVH
`define FBR_MAP_SVH

// register byte offsets on the control bus
`define FBR_OFS_STATUS 8'h00
`define FBR_OFS_CONFIG 8'h04
`define FBR_OFS_PROTECT 8'h08
`define FBR_OFS_INIT_ADDR 8'h0C
`define FBR_OFS_INIT_DATA 8'h10

// status field positions
`define FBR_ST_BUSY_LSB 0
`define FBR_ST_OK_BIT 2
`define FBR_ST_EMPTY_BIT 3

// config field positions
`define FBR_CFG_WRAP_BIT 0
`define FBR_CFG_SERIAL_BIT 1

// busy codes and reset values
`define FBR_BUSY_IDLE 2'h0
`define FBR_BUSY_READ 2'h3
`define FBR_RST_CONFIG 2'h0
`define FBR_RST_PROTECT 1'h0
`define FBR_BLANK_WORD 32'hFFFFFFFF

// bus responses
`define FBR_RESP_OKAY 2'h0
`define FBR_RESP_SLVERR 2'h2

`endif

//--- verilog/fbr_pkg.sv
package fbr_pkg;

  // read engine states
  typedef enum logic {ST_IDLE, ST_READ} fbr_state_e;

  // configuration as software writes it
  typedef struct packed {
    logic serial;
    logic wrap;
  } fbr_cfg_s;

  // status word as software reads it, bit 3 downward
  typedef struct packed {
    logic empty;
    logic read_ok;
    logic [1:0] busy;
  } fbr_status_s;

endpackage : fbr_pkg

//--- testbench/fbr_rd_master.sv
`timescale 1ns/1ns
// data port master: holds a read until taken, takes words with optional stalls
module fbr_rd_master (
  // clock and stall mode
  input wire logic clk_i,
  input wire logic slow_i,
  // data port
  input wire logic wait_i,
  input wire logic valid_i,
  input wire logic [31:0] rdata_i,
  output logic read_o,
  output logic [15:0] addr_o,
  output logic [7:0] burst_o,
  output logic ready_o
);
  logic [31:0] got[$];
  int age = 0;
  initial begin
    read_o = 1'b0;
    addr_o = 16'h0000;
    burst_o = 8'h00;
    ready_o = 1'b1;
  end
  // slow mode stalls 40 cycles so the fifo fills, then takes every other cycle
  always @(posedge clk_i) begin
    age <= read_o ? 0 : age + 1;
    ready_o <= !slow_i || (age > 40 && age[0]);
    if (valid_i === 1'b1 && ready_o === 1'b1) got.push_back(rdata_i);
  end
  // one command, held stable until waitrequest is sampled low
  task automatic burst(input logic [15:0] a, input logic [7:0] n);
    @(posedge clk_i);
    read_o <= 1'b1;
    addr_o <= a;
    burst_o <= n;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    read_o <= 1'b0;
    addr_o <= ~a; // released lines never show the stale value
    burst_o <= ~n;
  endtask : burst
endmodule : fbr_rd_master

//--- testbench/fbr_top_test.sv
`timescale 1ns/1ns
`include "fbr_map.svh"
module fbr_top_test;
  localparam int MEM = 256;
  localparam int WL = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [1:0] bext = 2'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awr, wrd, bv, arr, rv, wq, dv, rdy, drd;
  logic [1:0] br, rr;
  logic [31:0] rdat, ddat;
  logic [15:0] dad;
  logic [7:0] dbu;
  int failures = 0;
  int checks = 0;
  int i;
  // 20 MHz clock
  always #25 clk = ~clk;
  // design and data port master
  fbr_top fbr_top_inst (.CLK_I(clk), .RESET_I(rst), .DATA_READ_I(drd), .DATA_ADDR_I(dad), .DATA_BURST_I(dbu),
    .DATA_WAITREQUEST_O(wq), .DATA_VALID_O(dv), .DATA_READY_I(rdy), .DATA_RDATA_O(ddat), .BUSY_EXT_I(bext),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd),
    .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_BVALID_O(bv), .AXI_BREADY_I(bre), .AXI_BRESP_O(br),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv), .AXI_RREADY_I(rre),
    .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr));
  fbr_rd_master fbr_rd_master_inst (.clk_i(clk), .slow_i(slow), .wait_i(wq), .valid_i(dv), .rdata_i(ddat),
    .read_o(drd), .addr_o(dad), .burst_o(dbu), .ready_o(rdy));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // control bus write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    for (n = 0; n < 100 && bv !== 1'b1; n++) begin
      @(posedge clk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrd === 1'b1) wv <= 1'b0;
    end
    bre <= 1'b0;
    chk("write handshake", 32'h1, 32'(bv));
    chk("write resp", 32'(er), 32'(br));
  endtask : axi_wr
  // control bus read, data compared under a mask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input logic [31:0] m = 32'hFFFFFFFF);
    int n;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    for (n = 0; n < 100 && rv !== 1'b1; n++) begin
      @(posedge clk);
      if (arv && arr === 1'b1) arv <= 1'b0;
    end
    rre <= 1'b0;
    chk("read handshake", 32'h1, 32'(rv));
    chk("read data", ed, rdat & m);
    chk("read resp", 32'(er), 32'(rr));
  endtask : axi_rd
  // contents loaded below; everything else is blank
  function automatic logic [31:0] exp_word(input int a);
    if (a < 8) return 32'hA5000000 | 32'(a);
    if (a >= MEM - 2 && a < MEM) return 32'hC3000000 | 32'(a);
    return 32'hFFFFFFFF;
  endfunction : exp_word
  // one burst: k words expected, then status checked and, when ok is not expected, empty cleared
  task automatic rd(input int a, input int n, input int k, input bit wrap, input bit blank, input bit ok);
    int j;
    int w;
    fbr_rd_master_inst.got.delete();
    fbr_rd_master_inst.burst(a[15:0], n[7:0]);
    if (k == 0) repeat (20) @(posedge clk);
    for (w = 0; w < 3000 && fbr_rd_master_inst.got.size() < k; w++) @(posedge clk);
    chk("word count", 32'(k), 32'(fbr_rd_master_inst.got.size()));
    for (j = 0; j < k && j < fbr_rd_master_inst.got.size(); j++) begin
      w = wrap ? (a & ~(WL - 1)) | ((a + j) % WL) : (a + j) % MEM;
      chk("data word", blank ? 32'hFFFFFFFF : exp_word(w), fbr_rd_master_inst.got[j]);
    end
    while (wq !== 1'b0) @(posedge clk);
    axi_rd(`FBR_OFS_STATUS, ok ? 32'h4 : 32'h8, `FBR_RESP_OKAY);
    if (!ok) axi_wr(`FBR_OFS_STATUS, 32'h8, `FBR_RESP_OKAY);
  endtask : rd
  // test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    axi_rd(`FBR_OFS_STATUS, 32'h0, `FBR_RESP_OKAY);
    axi_rd(`FBR_OFS_CONFIG, 32'h0, `FBR_RESP_OKAY);
    axi_rd(`FBR_OFS_PROTECT, 32'h0, `FBR_RESP_OKAY);
    axi_rd(8'h14, 32'h0, `FBR_RESP_SLVERR);
    axi_rd(8'h02, 32'h0, `FBR_RESP_SLVERR);
    axi_wr(8'h14, 32'h1, `FBR_RESP_SLVERR);
    axi_wr(`FBR_OFS_INIT_ADDR, 32'h0, `FBR_RESP_OKAY);
    for (i = 0; i < 8; i++) axi_wr(`FBR_OFS_INIT_DATA, 32'hA5000000 | 32'(i), `FBR_RESP_OKAY);
    axi_wr(`FBR_OFS_INIT_ADDR, 32'(MEM - 2), `FBR_RESP_OKAY);
    for (i = 0; i < 3; i++) axi_wr(`FBR_OFS_INIT_DATA, 32'hC3000000 | 32'(MEM - 2 + i), `FBR_RESP_OKAY);
    rd(5, 1, 1, 1'b0, 1'b0, 1'b1);
    rd(0, 3, 3, 1'b0, 1'b0, 1'b1);
    rd(2, 5, 5, 1'b0, 1'b0, 1'b1);
    rd(8, 3, 3, 1'b0, 1'b0, 1'b1);
    slow <= 1'b1;
    rd(MEM - 2, 4, 4, 1'b0, 1'b0, 1'b1);
    fork
      rd(0, 128, 128, 1'b0, 1'b0, 1'b1);
      begin
        repeat (12) @(posedge clk);
        chk("waitrequest", 32'h1, 32'(wq));
        axi_rd(`FBR_OFS_STATUS, 32'h3, `FBR_RESP_OKAY, 32'h3);
      end
    join
    slow <= 1'b0;
    rd(0, 0, 0, 1'b0, 1'b0, 1'b0);
    rd(0, 129, 0, 1'b0, 1'b0, 1'b0);
    rd(MEM, 1, 1, 1'b0, 1'b1, 1'b0);
    axi_wr(`FBR_OFS_PROTECT, 32'h2, `FBR_RESP_OKAY);
    axi_rd(`FBR_OFS_PROTECT, 32'h2, `FBR_RESP_OKAY);
    rd(MEM - 1, 1, 1, 1'b0, 1'b1, 1'b0);
    axi_wr(`FBR_OFS_PROTECT, 32'h0, `FBR_RESP_OKAY);
    axi_wr(`FBR_OFS_CONFIG, 32'h1, `FBR_RESP_OKAY);
    rd(2, WL, WL, 1'b1, 1'b0, 1'b1);
    rd(4, WL, WL, 1'b1, 1'b0, 1'b1);
    rd(MEM - 2, WL, WL, 1'b1, 1'b0, 1'b1);
    rd(2, 2, 0, 1'b1, 1'b0, 1'b0);
    axi_wr(`FBR_OFS_CONFIG, 32'h3, `FBR_RESP_OKAY);
    rd(0, 32, 32, 1'b0, 1'b0, 1'b1);
    bext <= 2'h1;
    repeat (2) @(posedge clk);
    chk("waitrequest busy", 32'h1, 32'(wq));
    axi_rd(`FBR_OFS_STATUS, 32'h1, `FBR_RESP_OKAY, 32'h3);
    bext <= 2'h0;
    final_report();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : fbr_top_test
